// *** logic/slmd_decoder.sv ***
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module slmd_decoder (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_i,
  input wire logic strap_din_i,
  input wire logic strap_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [5:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  output logic comm_mode_o,
  output logic resp_o,
  output logic resp_oe_o
);

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_HALF,
    RX_B1,
    RX_M1,
    RX_BITS
  } slmd_rx_t;

  typedef struct packed {
    slmd_rx_t rx;
    logic sup_q1;
    logic sup_q2;
    logic sup_prev;
    logic din_q1;
    logic din_q2;
    logic sel_q1;
    logic sel_q2;
    logic [15:0] cnt;
    logic [15:0] half;
    logic [29:0] sh;
    logic [4:0] nbits;
    logic [2:0] crc;
    logic comm;
    logic ab;
    logic ov;
    logic ce;
    logic rd_pend;
    logic rd_bc;
    logic [5:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [15:0] wdata;
    logic tx_start;
    logic [26:0] tx_word;
    logic ctrl_dis;
    logic ctrl_spi;
    logic wb_ack;
    logic [31:0] wb_dat;
  } slmd_st_t;

  slmd_st_t st_r;
  slmd_st_t st_nxt;

  logic line;
  logic fall;
  logic rise;
  logic edge_any;
  logic [1:0] id;
  logic [15:0] cnt_inc;
  logic [17:0] lo_lim;
  logic [17:0] hi_lim;
  logic [17:0] cnt_w;
  logic in_win;
  logic cnt_to;
  logic is_rd;
  logic is_wr;
  logic finish;
  logic crc_ok;
  logic [3:0] tgt;
  logic [5:0] addr;
  logic [15:0] data;
  logic sel_hit;
  logic bc;
  logic tx_busy;
  logic [21:0] payload;

  // only the second stage of each synchroniser is looked at
  assign line = st_r.sup_q2;
  assign fall = st_r.sup_prev & ~line;
  assign rise = ~st_r.sup_prev & line;
  assign edge_any = fall | rise;
  assign id = {st_r.din_q2, st_r.sel_q2};

  assign cnt_inc = (st_r.cnt == slmd_pkg::CNT_MAX) ? st_r.cnt :
                   st_r.cnt + 16'h0001;
  // cell-boundary edges fall before 3/2 half-periods and are skipped
  assign lo_lim = {2'b00, st_r.half} + {3'b000, st_r.half[15:1]};
  assign hi_lim = {1'b0, st_r.half, 1'b0} + {3'b000, st_r.half[15:1]};
  assign cnt_w = {2'b00, st_r.cnt};
  assign in_win = (cnt_w >= lo_lim) && (cnt_w <= hi_lim);
  assign cnt_to = cnt_w > hi_lim;

  assign is_rd = (st_r.nbits == slmd_pkg::READ_BITS) && st_r.sh[13];
  assign is_wr = (st_r.nbits == slmd_pkg::WRITE_BITS) && !st_r.sh[29];
  assign finish = (st_r.rx == RX_BITS) && (is_rd || is_wr) &&
                  (st_r.cnt == st_r.half);
  assign crc_ok = st_r.crc == st_r.sh[2:0];
  assign tgt = is_rd ? st_r.sh[12:9] : st_r.sh[28:25];
  assign addr = is_rd ? st_r.sh[8:3] : st_r.sh[24:19];
  assign data = st_r.sh[18:3];
  assign sel_hit = (tgt == 4'h0) || tgt[id];
  assign bc = (tgt == 4'h0) || st_r.ctrl_spi;

  assign payload = {(st_r.rd_bc ? 2'b00 : id), st_r.rd_bc,
                    st_r.ab, st_r.ov, st_r.ce, reg_rdata_i};

  always_comb begin
    st_nxt = st_r;
    st_nxt.reg_rd = 1'b0;
    st_nxt.reg_wr = 1'b0;
    st_nxt.tx_start = 1'b0;
    st_nxt.wb_ack = 1'b0;
    st_nxt.sup_q1 = supply_i;
    st_nxt.sup_q2 = st_r.sup_q1;
    st_nxt.sup_prev = st_r.sup_q2;
    st_nxt.din_q1 = strap_din_i;
    st_nxt.din_q2 = st_r.din_q1;
    st_nxt.sel_q1 = strap_sel_i;
    st_nxt.sel_q2 = st_r.sel_q1;

    // register data arrives one cycle after the read strobe, so the
    // response is loaded only once the strobe has dropped
    if (st_r.rd_pend && !st_r.reg_rd) begin
      st_nxt.rd_pend = 1'b0;
      st_nxt.tx_start = 1'b1;
      st_nxt.tx_word = {2'b00, payload, slmd_pkg::crc_resp(payload)};
      // flags go out in this response; later events below still set them
      st_nxt.ab = 1'b0;
      st_nxt.ov = 1'b0;
      st_nxt.ce = 1'b0;
    end

    case (st_r.rx)
      RX_IDLE: begin
        st_nxt.cnt = 16'h0000;
        if (fall) begin
          st_nxt.rx = RX_HALF;
        end
      end
      RX_HALF: begin
        st_nxt.cnt = cnt_inc;
        if (rise) begin
          st_nxt.half = st_r.cnt + 16'h0001;
          st_nxt.cnt = 16'h0000;
          st_nxt.rx = (st_r.cnt >= slmd_pkg::HALF_MIN) ? RX_B1 : RX_IDLE;
        end else if (st_r.cnt == slmd_pkg::CNT_MAX) begin
          st_nxt.rx = RX_IDLE;
        end
      end
      RX_B1: begin
        st_nxt.cnt = cnt_inc;
        if (fall) begin
          st_nxt.cnt = 16'h0000;
          st_nxt.rx = RX_M1;
        end else if (cnt_to) begin
          st_nxt.rx = RX_IDLE;
        end
      end
      RX_M1: begin
        st_nxt.cnt = cnt_inc;
        if (rise) begin
          st_nxt.cnt = 16'h0000;
          st_nxt.nbits = 5'h00;
          st_nxt.crc = slmd_pkg::CRC_PRESET;
          st_nxt.sh = '0;
          st_nxt.rx = RX_BITS;
        end else if (fall || cnt_to) begin
          st_nxt.rx = RX_IDLE;
        end
      end
      RX_BITS: begin
        st_nxt.cnt = cnt_inc;
        if (finish) begin
          st_nxt.rx = RX_IDLE;
          if (tx_busy || st_r.rd_pend || st_r.tx_start) begin
            st_nxt.ov = 1'b1;
          end
          if (!crc_ok) begin
            st_nxt.ce = 1'b1;
          end else if (is_wr && addr == slmd_pkg::ACCESS_ADDR) begin
            st_nxt.comm = (data == slmd_pkg::ACCESS_KEY);
          end else if (st_r.comm && sel_hit) begin
            st_nxt.reg_addr = addr;
            if (is_wr) begin
              st_nxt.reg_wr = 1'b1;
              st_nxt.wdata = data;
            end else if (!(tx_busy || st_r.rd_pend || st_r.tx_start)) begin
              st_nxt.reg_rd = 1'b1;
              st_nxt.rd_pend = 1'b1;
              st_nxt.rd_bc = bc;
            end
          end
        end else if (edge_any && in_win) begin
          st_nxt.sh = {st_r.sh[28:0], fall};
          st_nxt.nbits = st_r.nbits + 5'h01;
          st_nxt.cnt = 16'h0000;
          if (st_r.nbits >= 5'h03) begin
            st_nxt.crc = slmd_pkg::crc_step(st_r.crc, st_r.sh[2]);
          end
          if (st_r.nbits == slmd_pkg::WRITE_BITS) begin
            st_nxt.ab = 1'b1;
            st_nxt.rx = RX_IDLE;
          end
        end else if (cnt_to) begin
          st_nxt.ab = 1'b1;
          st_nxt.rx = RX_IDLE;
        end
      end
      default: begin
        st_nxt.rx = RX_IDLE;
      end
    endcase

    if (st_r.ctrl_dis) begin
      st_nxt.rx = RX_IDLE;
    end

    if (wb_cyc_i && wb_stb_i && !st_r.wb_ack) begin
      st_nxt.wb_ack = 1'b1;
      st_nxt.wb_dat = 32'h0000_0000;
      if (wb_we_i) begin
        if (wb_adr_i == slmd_pkg::ADDR_CTRL && wb_sel_i[0]) begin
          st_nxt.ctrl_dis = wb_dat_i[slmd_pkg::CTRL_DIS_BIT];
          st_nxt.ctrl_spi = wb_dat_i[slmd_pkg::CTRL_SPI_BIT];
        end
      end else begin
        case (wb_adr_i)
          slmd_pkg::ADDR_CTRL: begin
            st_nxt.wb_dat[slmd_pkg::CTRL_DIS_BIT] = st_r.ctrl_dis;
            st_nxt.wb_dat[slmd_pkg::CTRL_SPI_BIT] = st_r.ctrl_spi;
          end
          slmd_pkg::ADDR_STATUS: begin
            st_nxt.wb_dat[6:0] = {id, tx_busy, st_r.ce, st_r.ov,
                                  st_r.ab, st_r.comm};
          end
          default: begin
            st_nxt.wb_dat = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.ctrl_dis <= slmd_pkg::CTRL_DIS_RST;
      st_r.ctrl_spi <= slmd_pkg::CTRL_SPI_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  logic tx_pull;

  // one frame in flight; a read that lands mid-response only flags overrun
  slmd_tx u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(st_r.tx_start),
    .half_i(st_r.half),
    .word_i(st_r.tx_word),
    .busy_o(tx_busy),
    .pull_low_o(tx_pull)
  );

  assign wb_dat_o = st_r.wb_dat;
  assign wb_ack_o = st_r.wb_ack;
  assign reg_addr_o = st_r.reg_addr;
  assign reg_rd_o = st_r.reg_rd;
  assign reg_wr_o = st_r.reg_wr;
  assign reg_wdata_o = st_r.wdata;
  assign comm_mode_o = st_r.comm;
  assign resp_o = 1'b0;
  assign resp_oe_o = tx_pull;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_abort_on_timeout: assert property (
    (st_r.rx == RX_BITS && !finish && !(edge_any && in_win) && cnt_to &&
     !st_r.ctrl_dis) |=> st_r.ab && st_r.rx == RX_IDLE)
    else $error("lost edge did not raise abort");
  a_bad_crc_drop: assert property (
    (finish && !crc_ok) |=> st_r.ce && !st_r.reg_wr && !st_r.reg_rd)
    else $error("bad check code frame was acted on");
  a_access_enter: assert property (
    (finish && crc_ok && is_wr && addr == slmd_pkg::ACCESS_ADDR &&
     data == slmd_pkg::ACCESS_KEY) |=> st_r.comm)
    else $error("access command did not enter comm mode");
  a_exit_leave: assert property (
    (finish && crc_ok && is_wr && addr == slmd_pkg::ACCESS_ADDR &&
     data != slmd_pkg::ACCESS_KEY) |=> !st_r.comm)
    else $error("exit command did not leave comm mode");
  a_write_gated: assert property (
    st_r.reg_wr |-> st_r.comm && $past(st_r.comm))
    else $error("write applied outside comm mode");
  a_read_to_resp: assert property (
    st_r.reg_rd |-> ##2 st_r.tx_start ##1 tx_busy)
    else $error("read strobe not followed by response start");
  a_bc_id_zero: assert property (
    (st_r.tx_start && st_r.tx_word[22]) |-> st_r.tx_word[24:23] == 2'b00)
    else $error("broadcast response carries nonzero identity");
  a_resp_crc: assert property (
    st_r.tx_start |-> st_r.tx_word[2:0] ==
      slmd_pkg::crc_resp(st_r.tx_word[24:3]) && st_r.tx_word[26:25] == 2'b00)
    else $error("response check code or sync wrong");
  a_overrun_set: assert property (
    (finish && tx_busy) |=> st_r.ov)
    else $error("overrun not flagged");
  a_disable_idle: assert property (
    st_r.ctrl_dis |=> st_r.rx == RX_IDLE)
    else $error("receiver active while disabled");

  c_access: cover property (finish && crc_ok && is_wr &&
                            data == slmd_pkg::ACCESS_KEY);
  c_read: cover property (st_r.reg_rd ##2 st_r.tx_start);
  c_write: cover property (st_r.reg_wr);
  c_overrun: cover property (finish && tx_busy);

endmodule : slmd_decoder

// *** logic/slmd_pkg.sv ***
// How it works
// - a falling mid-cell edge is a one, a rising mid-cell edge a zero
// - frames open with two zero bits that mark the start and the bit rate
// - then read/write bit, 4-bit target, 6-bit address, write data, 3-bit check
// - target bit at the die's identity position selects that die
// - all-zero target skips the identity test and acts as broadcast
// - identity is data strap as high bit and select strap as low bit
// - an accepted read is answered by a response frame on the open-drain line
// - every response carries identity and broadcast, abort, overrun, check flags
// - response identity is the strapped one, or zero when broadcast is set
// - broadcast is set for an all-zero target or while SPI mode is active
// - a missing expected edge after a recognised sync raises the abort flag
// - a command completed while a response is still sent raises overrun
// - a command with a wrong check code raises the check-code error flag
// - write and read are ignored until the access command has been seen
// - the access command is taken by every die whatever its target
// - access is a write to address all ones with data 0x62D2
// - a write to address all ones with other data ends communication mode
// - the read address selects the register sent in the response
// - every command ends in a 3-bit check code that is verified
// - check code x^3+x+1, preset 111, all bits after sync, msb first
// - response: sync, identity, four flags, 16 data bits, check code
// - error flags stay until reported in a response, then clear
// - with the disable bit set all supply-line activity is ignored
package slmd_pkg;

  localparam int unsigned CNT_W = 16;
  localparam logic [4:0] READ_BITS = 5'h0E;
  localparam logic [4:0] WRITE_BITS = 5'h1E;
  localparam logic [4:0] RESP_LAST = 5'h1A;
  localparam logic [15:0] HALF_MIN = 16'h0002;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [5:0] ACCESS_ADDR = 6'h3F;
  localparam logic [15:0] ACCESS_KEY = 16'h62D2;
  localparam logic [2:0] CRC_PRESET = 3'h7;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int unsigned CTRL_DIS_BIT = 0;
  localparam int unsigned CTRL_SPI_BIT = 1;
  localparam logic CTRL_DIS_RST = 1'b0;
  localparam logic CTRL_SPI_RST = 1'b0;

  function automatic logic [2:0] crc_step(input logic [2:0] c,
                                          input logic d);
    logic f;
    f = c[2] ^ d;
    return {c[1], c[0] ^ f, f};
  endfunction : crc_step

  function automatic logic [2:0] crc_resp(input logic [21:0] d);
    logic [2:0] c;
    c = CRC_PRESET;
    for (int i = 21; i >= 0; i--) begin
      c = crc_step(c, d[i]);
    end
    return c;
  endfunction : crc_resp

endpackage : slmd_pkg

// *** logic/slmd_tx.sv ***
`timescale 1ns/1ps
module slmd_tx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [15:0] half_i,
  input wire logic [26:0] word_i,
  output logic busy_o,
  output logic pull_low_o
);

  typedef struct packed {
    logic busy;
    logic phase;
    logic [4:0] nbit;
    logic [15:0] cnt;
    logic [15:0] half;
    logic [26:0] sh;
    logic drv;
  } slmd_tx_st_t;

  slmd_tx_st_t st_r;
  slmd_tx_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start_i && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.phase = 1'b0;
      st_nxt.nbit = 5'h00;
      st_nxt.cnt = 16'h0000;
      st_nxt.half = half_i;
      st_nxt.sh = word_i;
    end else if (st_r.busy) begin
      if (st_r.cnt + 16'h0001 >= st_r.half) begin
        st_nxt.cnt = 16'h0000;
        st_nxt.phase = ~st_r.phase;
        if (st_r.phase) begin
          st_nxt.sh = {st_r.sh[25:0], 1'b0};
          st_nxt.nbit = st_r.nbit + 5'h01;
          if (st_r.nbit == slmd_pkg::RESP_LAST) begin
            st_nxt.busy = 1'b0;
          end
        end
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end
    // one: high then low, zero: low then high; released line reads high
    st_nxt.drv = st_nxt.busy & ~(st_nxt.sh[26] ^ st_nxt.phase);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy;
  assign pull_low_o = st_r.drv;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_idle_released: assert property (!st_r.busy |-> !st_r.drv)
    else $error("response line driven while idle");
  a_first_bit_low: assert property ($rose(st_r.busy) |-> st_r.drv)
    else $error("response does not open with a sync zero");
  c_resp_done: cover property ($fell(st_r.busy));

endmodule : slmd_tx

// *** tb/slmd_ctrl_model.sv ***
`timescale 1ns/1ps
module slmd_ctrl_model #(
  parameter int HALF = 8
) (
  input wire logic clk_i,
  input wire logic resp_oe_i,
  output logic supply_o
);
  // supply idles high; single die on the line, so reads never collide
  initial supply_o = 1'b1;

  // two zero sync cells, then n bits msb first; first half holds the bit
  task automatic send(input logic [29:0] b, input int n);
    logic v;
    for (int i = n + 1; i >= 0; i--) begin
      v = (i < n) ? b[i] : 1'b0;
      supply_o <= v;
      repeat (HALF) @(posedge clk_i);
      supply_o <= !v;
      repeat (HALF) @(posedge clk_i);
    end
    supply_o <= 1'b1;
  endtask : send

  // samples mid first half of each cell; line is low while pulled
  task automatic get(output logic [26:0] w, output logic ok);
    ok = 1'b0;
    w = 27'h0;
    for (int t = 0; t < 40 * HALF && ok !== 1'b1; t++) begin
      @(posedge clk_i);
      ok = resp_oe_i;
    end
    if (ok === 1'b1) begin
      repeat (HALF / 2) @(posedge clk_i);
      for (int i = 26; i >= 0; i--) begin
        w[i] = !resp_oe_i;
        repeat (2 * HALF) @(posedge clk_i);
      end
    end
  endtask : get
endmodule : slmd_ctrl_model

// *** tb/slmd_decoder_tb_top.sv ***
`timescale 1ns/1ps
module slmd_decoder_tb_top;
  localparam int H = 8;
  logic [1:0] die_id = 2'b10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_i;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] reg_addr_o;
  logic reg_rd_o;
  logic reg_wr_o;
  logic [15:0] reg_wdata_o;
  logic [15:0] reg_rdata_i = 16'h0;
  logic comm_mode_o;
  logic resp_o;
  logic resp_oe_o;
  int fail_count = 0;
  int n_checks = 0;
  int wr_n = 0;
  int rd_n = 0;
  logic [21:0] wr_last = 22'h0;
  logic [31:0] q;

  always #12.5 clk_i = !clk_i;

  slmd_decoder i_slmd_decoder (.clk_i(clk_i), .rst_i(rst_i),
    .supply_i(supply_i), .strap_din_i(die_id[1]), .strap_sel_i(die_id[0]),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reg_addr_o(reg_addr_o),
    .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
    .reg_rdata_i(reg_rdata_i), .comm_mode_o(comm_mode_o),
    .resp_o(resp_o), .resp_oe_o(resp_oe_o));

  slmd_ctrl_model #(.HALF(H)) i_slmd_ctrl_model (.clk_i(clk_i),
    .resp_oe_i(resp_oe_o), .supply_o(supply_i));

  // register file stand-in: data encodes the address so a wrong pick shows
  always @(posedge clk_i) begin
    reg_rdata_i <= {4'hA, reg_addr_o, reg_addr_o};
    if (reg_rd_o === 1'b1) begin
      rd_n <= rd_n + 1;
    end
    if (reg_wr_o === 1'b1) begin
      wr_n <= wr_n + 1;
      wr_last <= {reg_addr_o, reg_wdata_o};
    end
  end

  function automatic logic [2:0] crc3(input logic [26:0] d, input int n);
    logic [2:0] c;
    logic f;
    c = 3'h7;
    for (int i = n - 1; i >= 0; i--) begin
      f = c[2] ^ d[i];
      c = {c[1], c[0] ^ f, f};
    end
    return c;
  endfunction : crc3

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task automatic print_verdict;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic cmd(input logic rw, input logic [3:0] t,
                     input logic [5:0] a, input logic [15:0] d,
                     input logic [2:0] bad);
    logic [26:0] b;
    b = rw ? {16'h0, 1'b1, t, a} : {1'b0, t, a, d};
    i_slmd_ctrl_model.send({b, crc3(b, rw ? 11 : 27) ^ bad},
                           rw ? 14 : 30);
  endtask : cmd

  task automatic rd(input logic [3:0] t, input logic [5:0] a,
                    input logic [2:0] bad, input logic want,
                    input logic [3:0] fl);
    logic [26:0] w;
    logic ok;
    logic [21:0] e;
    int n0;
    n0 = rd_n;
    e = {(fl[3] ? 2'b00 : die_id), fl, 4'hA, a, a};
    cmd(1'b1, t, a, 16'h0, bad);
    i_slmd_ctrl_model.get(w, ok);
    chk({31'h0, ok}, {31'h0, want}, "answer");
    chk(rd_n - n0, {31'h0, want}, "read strobe");
    if (want === 1'b1) begin
      chk({5'h0, w}, {7'h0, e, crc3({5'h0, e}, 22)}, "resp");
    end
    repeat (4 * H) @(posedge clk_i);
  endtask : rd

  task automatic wr(input logic [3:0] t, input logic [5:0] a,
                    input logic [15:0] d, input logic take);
    int n0;
    n0 = wr_n;
    cmd(1'b0, t, a, d, 3'h0);
    repeat (2 * H) @(posedge clk_i);
    chk(wr_n - n0, {31'h0, take}, "write count");
    if (take === 1'b1) begin
      chk({10'h0, wr_last}, {10'h0, a, d}, "write");
    end
  endtask : wr

  task automatic s_regs;
    chk({31'h0, resp_o}, 32'h0, "resp level");
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h0, "ctrl reset");
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, {25'h0, die_id, 5'h0}, "status reset");
    wb(1'b1, 8'h08, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0, "unmapped");
  endtask : s_regs

  task automatic s_lock;
    rd(4'b0100, 6'h01, 3'h0, 1'b0, 4'h0);
    wr(4'b0100, 6'h01, 16'h1234, 1'b0);
    cmd(1'b0, 4'b0001, 6'h3F, 16'h62D2, 3'h0);
    repeat (H) @(posedge clk_i);
    chk({31'h0, comm_mode_o}, 32'h1, "access");
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, {25'h0, die_id, 5'h1}, "status comm");
  endtask : s_lock

  task automatic s_reads;
    rd(4'b0000, 6'h20, 3'h0, 1'b1, 4'h8);
    rd(4'b0100, 6'h15, 3'h0, 1'b1, 4'h0);
    rd(4'b1100, 6'h2A, 3'h0, 1'b1, 4'h0);
    rd(4'b1011, 6'h3E, 3'h0, 1'b0, 4'h0);
    wr(4'b0100, 6'h05, 16'hBEEF, 1'b1);
    wr(4'b0000, 6'h06, 16'h0001, 1'b1);
    wr(4'b1011, 6'h07, 16'h8000, 1'b0);
  endtask : s_reads

  task automatic s_errors;
    rd(4'b0100, 6'h12, 3'h4, 1'b0, 4'h0);
    rd(4'b0100, 6'h13, 3'h0, 1'b1, 4'h1);
    rd(4'b0100, 6'h14, 3'h0, 1'b1, 4'h0);
    // short frame: edges simply stop after eight bits
    i_slmd_ctrl_model.send(30'h0000_00A5, 8);
    repeat (8 * H) @(posedge clk_i);
    rd(4'b0100, 6'h16, 3'h0, 1'b1, 4'h4);
    fork
      rd(4'b0100, 6'h17, 3'h0, 1'b1, 4'h0);
      begin
        wait (resp_oe_o === 1'b1);
        @(posedge clk_i);
        cmd(1'b1, 4'b0100, 6'h18, 16'h0, 3'h0);
      end
    join
    rd(4'b0100, 6'h19, 3'h0, 1'b1, 4'h2);
  endtask : s_errors

  task automatic s_modes;
    wb(1'b1, 8'h00, 32'h2, q);
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h2, "ctrl readback");
    rd(4'b0100, 6'h21, 3'h0, 1'b1, 4'h8);
    wb(1'b1, 8'h00, 32'h1, q);
    rd(4'b0100, 6'h22, 3'h0, 1'b0, 4'h0);
    wb(1'b1, 8'h00, 32'h0, q);
    rd(4'b0100, 6'h23, 3'h0, 1'b1, 4'h0);
    // restrap the die: identity follows the pins after the synchronisers
    die_id <= 2'b01;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, {25'h0, die_id, 5'h1}, "status strap");
    rd(4'b0010, 6'h25, 3'h0, 1'b1, 4'h0);
    rd(4'b0100, 6'h26, 3'h0, 1'b0, 4'h0);
  endtask : s_modes

  task automatic s_exit;
    cmd(1'b0, 4'b0010, 6'h3F, 16'h0000, 3'h0);
    repeat (H) @(posedge clk_i);
    chk({31'h0, comm_mode_o}, 32'h0, "exit");
    rd(4'b0010, 6'h24, 3'h0, 1'b0, 4'h0);
  endtask : s_exit

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    s_regs();
    s_lock();
    s_reads();
    s_errors();
    s_modes();
    s_exit();
    print_verdict();
  end

  // about 15k cycles expected; generous margin for slow responses
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    print_verdict();
  end
endmodule : slmd_decoder_tb_top
